// ### hw/ppad_pkg.sv
// constants shared by the parallel port address decoder
package ppad_pkg;
  // ==========================================================
  // host i/o address space
  localparam logic [15:0] slot_area_start   = 16'hC000;
  localparam logic [15:0] slot_window_span  = 16'h0020;
  localparam logic [15:0] off_config        = 16'h0000;
  localparam logic [15:0] off_module_id     = 16'h0001;
  localparam logic [15:0] off_port_first    = 16'h0010;
  localparam logic [15:0] off_port_last     = 16'h0017;
  localparam logic [15:0] legacy_base_378   = 16'h0378;
  localparam logic [15:0] legacy_last_378   = 16'h037F;
  localparam logic [15:0] legacy_base_278   = 16'h0278;
  localparam logic [15:0] legacy_last_278   = 16'h027F;
  localparam logic [15:0] legacy_base_3bc   = 16'h03BC;
  localparam logic [15:0] legacy_last_3bc   = 16'h03BE;

  // ==========================================================
  // configuration register layout
  localparam int          select_lsb        = 0;
  localparam int          select_msb        = 1;
  localparam logic [5:0]  config_upper_read = 6'h3F;
  localparam logic [7:0]  unmapped_read     = 8'h00;

  // legacy address select encodings
  typedef enum logic [1:0] {
    sel_slot_only = 2'h0,
    sel_378       = 2'h1,
    sel_278       = 2'h2,
    sel_3bc       = 2'h3
  } legacy_sel_t;
  localparam legacy_sel_t select_reset = sel_slot_only;

  // ==========================================================
  // parallel port register indices and resets
  localparam logic [2:0] pp_data    = 3'h0;
  localparam logic [2:0] pp_status  = 3'h1;
  localparam logic [2:0] pp_control = 3'h2;
  localparam logic [7:0] pp_data_reset    = 8'h00;
  localparam logic [5:0] pp_control_reset = 6'h00;
  localparam logic [7:0] pp_spare_read    = 8'hFF;
  localparam logic [2:0] pp_status_low    = 3'h7;
  localparam int ctl_strobe = 0;
  localparam int ctl_autofd = 1;
  localparam int ctl_init   = 2;
  localparam int ctl_selin  = 3;
  localparam int ctl_irq_en = 4;
  localparam int ctl_dir_in = 5;
endpackage

// ### hw/pp_access_if.sv
// register access carrier between decoder and parallel port core
interface pp_access_if;
  logic       rd;     // one-cycle read strobe
  logic       wr;     // one-cycle write strobe
  logic [2:0] index;  // register index within the port
  logic [7:0] wdata;  // write data
  logic [7:0] rdata;  // combinational read data

  modport decoder (output rd, output wr, output index, output wdata,
                   input rdata);
  modport port    (input rd, input wr, input index, input wdata,
                   output rdata);
endinterface

// ### hw/parallel_port_core.sv
// standard parallel port register set with pin logic and interrupt
module parallel_port_core (
  input  wire logic       sys_clk,         // host bus clock
  input  wire logic       reset,           // async, active high
  pp_access_if.port       acc,             // register access
  input  wire logic [7:0] pin_data_in,     // data pins, sensed
  output logic      [7:0] pin_data_out,    // data pins, driven
  output logic            pin_data_oe_n,   // low while driving
  output logic            pin_strobe_n,    // strobe, active low
  output logic            pin_autofd_n,    // auto feed, active low
  output logic            pin_init_n,      // printer reset, active low
  output logic            pin_selin_n,     // select in, active low
  input  wire logic       pin_ack_n,       // acknowledge, active low
  input  wire logic       pin_busy,        // busy
  input  wire logic       pin_paper_end,   // paper end
  input  wire logic       pin_select,      // select
  input  wire logic       pin_error_n,     // error, active low
  output logic            module_irq_line  // interrupt request
);
  logic [12:0] sync_a;
  logic [12:0] sync_b;
  logic [7:0]  data_latch;
  logic [5:0]  control;
  logic        ack_prev;
  logic        irq_pend;
  logic        ack_fall;
  logic        status_rd;
  logic [7:0]  status_word;

  // ==========================================================
  // two-stage synchronisers for all pin inputs
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {pin_data_in, pin_ack_n, pin_busy, pin_paper_end,
                 pin_select, pin_error_n};
      sync_b <= sync_a;
    end
  end

  // decoded events and status image
  assign ack_fall    = ack_prev & ~sync_b[4];
  assign status_rd   = acc.rd & (acc.index == ppad_pkg::pp_status);
  assign status_word = {~sync_b[3], sync_b[4], sync_b[2], sync_b[1],
                        sync_b[0], ppad_pkg::pp_status_low};

  // read data selection
  always_comb begin
    case (acc.index)
      ppad_pkg::pp_data:
        acc.rdata = control[ppad_pkg::ctl_dir_in] ? sync_b[12:5]
                                                  : data_latch;
      ppad_pkg::pp_status:  acc.rdata = status_word;
      ppad_pkg::pp_control: acc.rdata = {2'b11, control};
      default:              acc.rdata = ppad_pkg::pp_spare_read;
    endcase
  end

  // ==========================================================
  // data and control registers, pins driven from flops
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_latch    <= ppad_pkg::pp_data_reset;
      control       <= ppad_pkg::pp_control_reset;
      pin_data_out  <= ppad_pkg::pp_data_reset;
      pin_data_oe_n <= 1'b0;
      pin_strobe_n  <= 1'b1;
      pin_autofd_n  <= 1'b1;
      pin_init_n    <= 1'b1;
      pin_selin_n   <= 1'b1;
    end else if (acc.wr) begin
      if (acc.index == ppad_pkg::pp_data) begin
        data_latch   <= acc.wdata;
        pin_data_out <= acc.wdata;
      end
      if (acc.index == ppad_pkg::pp_control) begin
        control       <= acc.wdata[5:0];
        pin_data_oe_n <= acc.wdata[ppad_pkg::ctl_dir_in];
        pin_strobe_n  <= ~acc.wdata[ppad_pkg::ctl_strobe];
        pin_autofd_n  <= ~acc.wdata[ppad_pkg::ctl_autofd];
        pin_init_n    <= acc.wdata[ppad_pkg::ctl_init];
        pin_selin_n   <= ~acc.wdata[ppad_pkg::ctl_selin];
      end
    end
  end

  // ==========================================================
  // acknowledge edge latches the request; set wins over read clear
  // ack_prev resets low like the synchroniser: no false edge after reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ack_prev        <= 1'b0;
      irq_pend        <= 1'b0;
      module_irq_line <= 1'b0;
    end else begin
      ack_prev <= sync_b[4];
      if (ack_fall & control[ppad_pkg::ctl_irq_en])
        irq_pend <= 1'b1;
      else if (status_rd)
        irq_pend <= 1'b0;
      module_irq_line <= irq_pend & control[ppad_pkg::ctl_irq_en];
    end
  end
endmodule

// ### hw/parallel_port_address_decoder.sv
// host i/o decoder, configuration register and id for the port module
// ============================================================
module parallel_port_address_decoder #(
  parameter logic [7:0] module_id_code = 8'h5A  // arbitrary value
) (
  input  wire logic        sys_clk,         // host bus clock, 125 MHz
  input  wire logic        reset,           // async, active high
  input  wire logic [15:0] slot_base,       // slot-dependent base
  input  wire logic [15:0] io_addr,         // host i/o address
  input  wire logic        io_rd,           // one-cycle read strobe
  input  wire logic        io_wr,           // one-cycle write strobe
  input  wire logic [7:0]  io_wdata,        // host write data
  output logic      [7:0]  io_rdata,        // read data, next cycle
  output logic             io_ack,          // access claimed, pulse
  input  wire logic [7:0]  pin_data_in,     // data pins, sensed
  output logic      [7:0]  pin_data_out,    // data pins, driven
  output logic             pin_data_oe_n,   // low while driving
  output logic             pin_strobe_n,    // strobe, active low
  output logic             pin_autofd_n,    // auto feed, active low
  output logic             pin_init_n,      // printer reset, active low
  output logic             pin_selin_n,     // select in, active low
  input  wire logic        pin_ack_n,       // acknowledge, active low
  input  wire logic        pin_busy,        // busy
  input  wire logic        pin_paper_end,   // paper end
  input  wire logic        pin_select,      // select
  input  wire logic        pin_error_n,     // error, active low
  output logic             module_irq_line, // interrupt request
  output logic      [1:0]  legacy_address_select // current setting
);
  pp_access_if acc ();

  logic [15:0] slot_off;
  logic        in_slot;
  logic        hit_config;
  logic        hit_id;
  logic        hit_slot_port;
  logic [15:0] leg_base;
  logic [15:0] leg_last;
  logic [15:0] leg_off;
  logic        hit_legacy;
  logic        hit_port;
  logic        hit_any;
  logic [2:0]  port_index;
  logic [7:0]  config_read;
  logic [7:0]  next_rdata;

  // ==========================================================
  // slot area decode: offset relative to slot base
  assign slot_off   = io_addr - slot_base;
  assign in_slot    = (io_addr >= ppad_pkg::slot_area_start) &
                      (io_addr >= slot_base) &
                      (slot_off < ppad_pkg::slot_window_span);
  assign hit_config = in_slot & (slot_off == ppad_pkg::off_config);
  assign hit_id     = in_slot & (slot_off == ppad_pkg::off_module_id);
  assign hit_slot_port = in_slot &
                         (slot_off >= ppad_pkg::off_port_first) &
                         (slot_off <= ppad_pkg::off_port_last);

  // ==========================================================
  // legacy window chosen by the select field
  always_comb begin
    case (legacy_address_select)
      ppad_pkg::sel_378: begin
        leg_base = ppad_pkg::legacy_base_378;
        leg_last = ppad_pkg::legacy_last_378;
      end
      ppad_pkg::sel_278: begin
        leg_base = ppad_pkg::legacy_base_278;
        leg_last = ppad_pkg::legacy_last_278;
      end
      ppad_pkg::sel_3bc: begin
        leg_base = ppad_pkg::legacy_base_3bc;
        leg_last = ppad_pkg::legacy_last_3bc;
      end
      default: begin
        leg_base = ppad_pkg::legacy_base_378;
        leg_last = ppad_pkg::legacy_last_378;
      end
    endcase
  end

  // legacy hit is suppressed while slot-only is selected
  assign leg_off    = io_addr - leg_base;
  assign hit_legacy = (legacy_address_select != ppad_pkg::sel_slot_only) &
                      (io_addr >= leg_base) &
                      (io_addr <= leg_last);

  // port index from whichever window hit; slot wins
  assign hit_port   = hit_slot_port | hit_legacy;
  assign port_index = hit_slot_port ? slot_off[2:0] : leg_off[2:0];
  assign hit_any    = hit_config | hit_id | hit_port;

  // ==========================================================
  // access to the port core
  assign acc.rd    = io_rd & hit_port;
  assign acc.wr    = io_wr & hit_port;
  assign acc.index = port_index;
  assign acc.wdata = io_wdata;

  // read image of the configuration register
  assign config_read = {ppad_pkg::config_upper_read,
                        legacy_address_select};

  // read data selection
  assign next_rdata = hit_config ? config_read :
                      hit_id     ? module_id_code :
                      hit_port   ? acc.rdata :
                                   ppad_pkg::unmapped_read;

  // ==========================================================
  // configuration register: only the select bits are stored
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset)
      legacy_address_select <= ppad_pkg::select_reset;
    else if (io_wr & hit_config)
      legacy_address_select <=
        io_wdata[ppad_pkg::select_msb:ppad_pkg::select_lsb];
  end

  // answer one cycle after the strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      io_rdata <= ppad_pkg::unmapped_read;
      io_ack   <= 1'b0;
    end else begin
      io_ack   <= (io_rd | io_wr) & hit_any;
      io_rdata <= (io_rd & hit_any) ? next_rdata
                                    : ppad_pkg::unmapped_read;
    end
  end

  // parallel port controller
  parallel_port_core core (
    .sys_clk         (sys_clk),
    .reset           (reset),
    .acc             (acc),
    .pin_data_in     (pin_data_in),
    .pin_data_out    (pin_data_out),
    .pin_data_oe_n   (pin_data_oe_n),
    .pin_strobe_n    (pin_strobe_n),
    .pin_autofd_n    (pin_autofd_n),
    .pin_init_n      (pin_init_n),
    .pin_selin_n     (pin_selin_n),
    .pin_ack_n       (pin_ack_n),
    .pin_busy        (pin_busy),
    .pin_paper_end   (pin_paper_end),
    .pin_select      (pin_select),
    .pin_error_n     (pin_error_n),
    .module_irq_line (module_irq_line)
  );
endmodule

// ### tb/ppad_monitor.sv
// assertion checker watching the decoder's host bus ports
module ppad_monitor #(
  parameter logic [7:0] module_id_code = 8'h5A // arbitrary value
) (
  input wire logic        sys_clk,              // host bus clock
  input wire logic        reset,                // async, active high
  input wire logic [15:0] slot_base,            // slot base
  input wire logic [15:0] io_addr,              // host address
  input wire logic        io_rd,                // read strobe
  input wire logic        io_wr,                // write strobe
  input wire logic [7:0]  io_wdata,             // write data
  input wire logic [7:0]  io_rdata,             // read data
  input wire logic        io_ack,               // access claimed
  input wire logic [1:0]  legacy_address_select // current setting
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // decode helpers
  wire        acc     = io_rd | io_wr;
  wire [15:0] off     = io_addr - slot_base;
  wire        in_slot = io_addr >= 16'hC000 && off < 16'h0020;
  wire [1:0]  sel     = legacy_address_select;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // properties
  sequence s_cfg_rd;
    io_rd && in_slot && off == 16'h0000;
  endsequence
  sequence s_answer;
    io_ack ##0 io_rdata[7:2] == 6'h3F;
  endsequence
  property p_cfg_read;
    s_cfg_rd |=> s_answer ##0 io_rdata[1:0] == sel;
  endproperty
  property p_sel_write;
    io_wr && in_slot && off == 16'h0000 |=> sel == $past(io_wdata[1:0]);
  endproperty
  property p_port_hit;
    acc && in_slot && off[15:3] == 13'h0002 |=> io_ack;
  endproperty
  property p_id_read;
    io_rd && in_slot && off == 16'h0001
      |=> io_ack && io_rdata == module_id_code;
  endproperty
  property p_leg_378;
    acc && sel == 2'h1 && io_addr[15:3] == 13'h006F |=> io_ack;
  endproperty
  property p_leg_278;
    acc && sel == 2'h2 && io_addr[15:3] == 13'h004F |=> io_ack;
  endproperty
  property p_leg_3bc;
    acc && sel == 2'h3 && io_addr[15:2] == 14'h00EF
      |=> io_ack == ($past(io_addr[1:0]) != 2'h3);
  endproperty
  property p_leg_off;
    acc && sel == 2'h0 && io_addr < 16'h0400 |=> !io_ack;
  endproperty
  property p_quiet;
    !acc |=> !io_ack && io_rdata == 8'h00;
  endproperty
  a_cfg_read:  assert property (p_cfg_read) else $error("config read");
  a_sel_write: assert property (p_sel_write) else $error("select");
  a_port_hit:  assert property (p_port_hit) else $error("port");
  a_id_read:   assert property (p_id_read) else $error("id read");
  a_leg_378:   assert property (p_leg_378) else $error("0x378");
  a_leg_278:   assert property (p_leg_278) else $error("0x278");
  a_leg_3bc:   assert property (p_leg_3bc) else $error("0x3BC");
  a_leg_off:   assert property (p_leg_off) else $error("legacy");
  a_quiet:     assert property (p_quiet) else $error("idle");
endmodule

bind parallel_port_address_decoder ppad_monitor #(
  .module_id_code(module_id_code)
) u_mon (
  .sys_clk(sys_clk), .reset(reset), .slot_base(slot_base),
  .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .io_ack(io_ack),
  .legacy_address_select(legacy_address_select)
);

// ### tb/printer_model.sv
// printer side model: acknowledges each strobe, holds status pins
module printer_model (
  input  wire logic       sys_clk,       // clock
  input  wire logic [7:0] pin_data_out,  // data from port
  input  wire logic       pin_strobe_n,  // strobe from port
  input  wire logic       pin_data_oe_n, // port drives data when low
  output logic      [7:0] pin_data_in,   // data sensed by port
  output logic            pin_ack_n,     // acknowledge
  output logic            pin_busy,      // busy
  output logic            pin_paper_end, // paper end
  output logic            pin_select,    // select
  output logic            pin_error_n    // error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic strobe_q = 1'b1;
  int   cnt      = 0;
  // driven lines read back; released lines show the inverse
  assign pin_data_in   = pin_data_oe_n ? ~pin_data_out : pin_data_out;
  assign pin_busy      = 1'b0;
  assign pin_paper_end = 1'b0;
  assign pin_select    = 1'b1;
  assign pin_error_n   = 1'b1;
  assign pin_ack_n     = !(cnt inside {[1:2]});
  // two-cycle ack pulse, six cycles after strobe falls
  always @(posedge sys_clk) begin
    strobe_q <= pin_strobe_n;
    if (strobe_q && !pin_strobe_n) cnt <= 7;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the parallel port address decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] base = 16'hC100;
  localparam logic [15:0] base2 = 16'hC200;
  localparam logic [7:0]  id   = 8'h5A; // arbitrary value
  logic        sys_clk = 0, reset = 1, io_rd = 0, io_wr = 0, pend = 0;
  logic [15:0] slot_base = base, io_addr = 0;
  logic [7:0]  io_wdata = 0, io_rdata, pin_data_out, pin_data_in, w, latch;
  logic        io_ack, pin_data_oe_n, pin_strobe_n, pin_autofd_n;
  logic        pin_init_n, pin_selin_n, pin_ack_n, pin_busy, irq;
  logic        pin_paper_end, pin_select, pin_error_n;
  logic [1:0]  sel;
  logic [8:0]  notes[$];
  int          err_count = 0, samples_checked = 0, cycles = 0;
  int          seed = 32'h777b;
  int          need[6] = '{1, 1, 2, 2, 3, 4};
  logic [15:0] leg[6] = '{16'h0378, 16'h037F, 16'h0278, 16'h027F,
                          16'h03BC, 16'h03BF};
  parallel_port_address_decoder #(.module_id_code(id)) uut (
    .sys_clk(sys_clk), .reset(reset), .slot_base(slot_base),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_ack(io_ack), .pin_data_in(pin_data_in),
    .pin_data_out(pin_data_out), .pin_data_oe_n(pin_data_oe_n),
    .pin_strobe_n(pin_strobe_n), .pin_autofd_n(pin_autofd_n),
    .pin_init_n(pin_init_n), .pin_selin_n(pin_selin_n),
    .pin_ack_n(pin_ack_n), .pin_busy(pin_busy),
    .pin_paper_end(pin_paper_end), .pin_select(pin_select),
    .pin_error_n(pin_error_n), .module_irq_line(irq),
    .legacy_address_select(sel));
  printer_model u_prn (
    .sys_clk(sys_clk), .pin_data_out(pin_data_out),
    .pin_strobe_n(pin_strobe_n), .pin_data_oe_n(pin_data_oe_n),
    .pin_data_in(pin_data_in),
    .pin_ack_n(pin_ack_n), .pin_busy(pin_busy),
    .pin_paper_end(pin_paper_end), .pin_select(pin_select),
    .pin_error_n(pin_error_n));
  // ==========================================================
  // clock, timeout and shared tasks
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic rd, input logic [15:0] a,
                     input logic [7:0] d, input logic hit,
                     input logic [7:0] rx);
    io_rd <= rd;
    io_wr <= !rd;
    io_addr <= a;
    io_wdata <= d;
    notes.push_back({hit, (hit && rd) ? rx : 8'h00});
    @(posedge sys_clk);
  endtask
  task automatic idle(input int n);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic summarize;
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // answer watcher: one note per access, due the next cycle
  always @(negedge sys_clk) begin
    if (pend) chk({io_ack, io_rdata}, notes.pop_front());
    pend = io_rd | io_wr;
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk(sel, 2'h0);
    chk({irq, pin_strobe_n, io_ack}, 3'b010);
    $display("test reset done");
    latch = 8'($random(seed));
    acc(0, base + 16'h0010, latch, 1, 0);
    for (int s = 0; s < 4; s++) begin
      w = 8'($random(seed));
      w[1:0] = 2'(s);
      acc(0, base, w, 1, 0);
      acc(1, base, 0, 1, {6'h3F, w[1:0]});
      for (int i = 0; i < 6; i++)
        acc(1, leg[i], 0, need[i] == s,
            (leg[i][2:0] == 3'h7) ? 8'hFF : latch);
      acc(1, base + 16'h0001, 0, 1, id);
      acc(1, base + 16'h0002, 0, 0, 0);
      idle(1);
      chk(sel, w[1:0]);
    end
    acc(0, base, 8'h00, 1, 0);
    $display("test decode done");
    w = 8'($random(seed));
    acc(0, base + 16'h0010, w, 1, 0);
    acc(0, base + 16'h0012, 8'h11, 1, 0);
    acc(1, base + 16'h0010, 0, 1, w);
    acc(1, base + 16'h0012, 0, 1, 8'hD1);
    idle(2);
    chk({pin_strobe_n, pin_data_out}, {1'b0, w});
    acc(0, base + 16'h0012, 8'h10, 1, 0);
    idle(1);
    for (int k = 0; k < 40 && irq !== 1'b1; k++) @(posedge sys_clk);
    chk(irq, 1'b1);
    idle(6);
    acc(1, base + 16'h0011, 0, 1, 8'hDF);
    idle(3);
    chk(irq, 1'b0);
    $display("test port and interrupt done");
    // input direction, moved slot base, then a mid-run reset
    acc(0, base + 16'h0012, 8'h2E, 1, 0);
    idle(3);
    chk({pin_data_oe_n, pin_strobe_n, pin_autofd_n, pin_init_n,
         pin_selin_n}, 5'b11010);
    acc(1, base + 16'h0010, 0, 1, ~w);
    slot_base <= base2;
    acc(1, base2, 0, 1, 8'hFC);
    acc(1, base, 0, 0, 0);
    idle(1);
    reset <= 1'b1;
    idle(2);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk({sel, irq, pin_data_oe_n, pin_strobe_n, pin_autofd_n,
         pin_init_n, pin_selin_n}, 8'h0F);
    acc(1, base2 + 16'h0012, 0, 1, 8'hC0);
    idle(1);
    $display("test direction and reset done");
    summarize();
  end
endmodule
